// ### rtl/positioning_start_sequencer.sv
// Start selection sequencer for stored positioning entries.
//
// Contract
// - Start runs the entry shown on the four select inputs.
// - Ready is low during a move and high again when it completes.
// - A direct trigger runs its assigned entry without a select step.
// - Each trigger has its own entry 0 to 15; defaults 0 to 5.
// - Torque limit always comes from the entry on the select inputs.
// - Each step start runs the entry after the last one run.
// - A step reaching a sequence-disabled entry runs the sequence start instead.
// - Start or trigger moves record their entry as the sequence start.
// - With no prior selection the first step runs entry 0.
// - Sequence reset events set start to 0 and present entry to -1.
// - A single-motion entry runs once, then stops and reports completion.
// - Select inputs are straight binary, bit 0 least significant, entries 0-15.
`timescale 1ns/1ps
module positioning_start_sequencer import pss_pkg::*; #(
   parameter int NUM_TRIG = N_TRIG
) (
   input wire logic I_CLK_SYS, // System clock, 20 MHz.
   input wire logic I_RST_N, // Asynchronous reset, active low.
   input wire logic [ENTRY_W-1:0] I_SEL, // Binary entry select, bit 0 is the LSB.
   input wire logic I_START, // Start request, active high.
   input wire logic [NUM_TRIG-1:0] I_DTRIG, // Direct triggers, active high.
   input wire logic I_STEP_START, // Step start request, active high.
   input wire logic I_MOVE_DONE, // Motion engine finished the move.
   input wire logic I_SEQ_RESET, // Sequence reset event, level.
   input wire logic I_MAP_WE, // Write a trigger entry assignment.
   input wire logic [TRIG_IDX_W-1:0] I_MAP_IDX, // Trigger being assigned.
   input wire logic [ENTRY_W-1:0] I_MAP_ENTRY, // Entry assigned to that trigger.
   input wire logic I_CFG_WE, // Write an entry configuration.
   input wire logic [ENTRY_W-1:0] I_CFG_ADDR, // Entry being configured.
   input wire entry_cfg_t I_CFG_DATA, // Sequence enable and torque limit.
   output logic O_READY, // Ready for a new request.
   output logic O_MOVE_START, // One-cycle pulse to the motion engine.
   output logic [ENTRY_W-1:0] O_MOVE_ENTRY, // Entry being executed.
   output logic [TORQUE_W-1:0] O_TORQUE_LIMIT, // Torque limit of the selected entry.
   output logic [PRESENT_W-1:0] O_PRESENT_ENTRY, // Present entry, all ones for -1.
   output logic [ENTRY_W-1:0] O_SEQ_START, // Sequence starting entry.
   output logic O_COMPLETE // One-cycle pulse when a move completes.
);
   if (NUM_TRIG < 1 || NUM_TRIG > (1 << TRIG_IDX_W)) begin : g_bad_trig
      $error("positioning_start_sequencer: NUM_TRIG out of range");
   end

   seq_state_t state_r, state_nxt;
   logic [ENTRY_W-1:0] entry_r, entry_nxt;
   logic [ENTRY_W-1:0] seq_start_r, seq_start_nxt;
   logic [PRESENT_W-1:0] present_r, present_nxt;
   logic move_start_r, move_start_nxt;
   logic complete_r, complete_nxt;
   logic [ENTRY_W-1:0] map_r [NUM_TRIG];
   logic [ENTRY_W-1:0] map_nxt [NUM_TRIG];
   logic start_q, step_q;
   logic [NUM_TRIG-1:0] trig_q;
   logic rise_start, rise_step;
   logic [NUM_TRIG-1:0] rise_trig;
   entry_cfg_t rd_run;
   entry_cfg_t rd_sel;

   // Requests act on their rising edge so a held input cannot restart a move.
   assign rise_start = I_START & ~start_q;
   assign rise_step = I_STEP_START & ~step_q;
   assign rise_trig = I_DTRIG & ~trig_q;

   // Port B follows the select inputs for every kind of move.
   entry_table #(.DEPTH(N_ENTRY), .AW(ENTRY_W)) u_table (
      .i_clk(I_CLK_SYS),
      .i_rst_n(I_RST_N),
      .i_we(I_CFG_WE),
      .i_waddr(I_CFG_ADDR),
      .i_wdata(I_CFG_DATA),
      .i_raddr_a(entry_r),
      .o_rdata_a(rd_run),
      .i_raddr_b(I_SEL),
      .o_rdata_b(rd_sel)
   );

   always_comb begin
      for (int k = 0; k < NUM_TRIG; k++) begin
         map_nxt[k] = map_r[k];
      end
      if (I_MAP_WE && int'(I_MAP_IDX) < NUM_TRIG) begin
         map_nxt[I_MAP_IDX] = I_MAP_ENTRY;
      end
   end

   always_comb begin
      state_nxt = state_r;
      entry_nxt = entry_r;
      seq_start_nxt = seq_start_r;
      present_nxt = present_r;
      move_start_nxt = 1'b0;
      complete_nxt = 1'b0;
      case (state_r)
         ST_IDLE: begin
            // Only this state takes requests; all others ignore them.
            if (rise_start) begin
               entry_nxt = I_SEL;
               seq_start_nxt = I_SEL;
               present_nxt = {1'b0, I_SEL};
               move_start_nxt = 1'b1;
               state_nxt = ST_RUN;
            end else if (|rise_trig) begin
               for (int k = NUM_TRIG - 1; k >= 0; k--) begin
                  if (rise_trig[k]) begin
                     entry_nxt = map_r[k];
                     seq_start_nxt = map_r[k];
                     present_nxt = {1'b0, map_r[k]};
                  end
               end
               move_start_nxt = 1'b1;
               state_nxt = ST_RUN;
            end else if (rise_step) begin
               if (present_r == PRESENT_NONE) begin
                  // Nothing run yet: the sequence start itself runs.
                  entry_nxt = seq_start_r;
                  present_nxt = {1'b0, seq_start_r};
                  move_start_nxt = 1'b1;
                  state_nxt = ST_RUN;
               end else begin
                  entry_nxt = next_entry(present_r[ENTRY_W-1:0]);
                  state_nxt = ST_FETCH;
               end
            end
         end
         ST_FETCH: begin
            state_nxt = ST_CHECK;
         end
         ST_CHECK: begin
            if (!rd_run.seq_en) begin
               entry_nxt = seq_start_r;
               present_nxt = {1'b0, seq_start_r};
            end else begin
               present_nxt = {1'b0, entry_r};
            end
            move_start_nxt = 1'b1;
            state_nxt = ST_RUN;
         end
         ST_RUN: begin
            if (I_MOVE_DONE) begin
               complete_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      if (I_SEQ_RESET) begin
         seq_start_nxt = SEQ_START_RST;
         present_nxt = PRESENT_NONE;
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         state_r <= ST_IDLE;
         entry_r <= SEQ_START_RST;
         seq_start_r <= SEQ_START_RST;
         present_r <= PRESENT_NONE;
         move_start_r <= 1'b0;
         complete_r <= 1'b0;
         start_q <= 1'b0;
         step_q <= 1'b0;
         trig_q <= '0;
         for (int k = 0; k < NUM_TRIG; k++) begin
            map_r[k] <= map_default(k);
         end
      end else begin
         state_r <= state_nxt;
         entry_r <= entry_nxt;
         seq_start_r <= seq_start_nxt;
         present_r <= present_nxt;
         move_start_r <= move_start_nxt;
         complete_r <= complete_nxt;
         start_q <= I_START;
         step_q <= I_STEP_START;
         trig_q <= I_DTRIG;
         for (int k = 0; k < NUM_TRIG; k++) begin
            map_r[k] <= map_nxt[k];
         end
      end
   end

   // Ready is decoded from the state so it drops in the cycle after a request is taken.
   assign O_READY = (state_r == ST_IDLE);
   assign O_MOVE_START = move_start_r;
   assign O_MOVE_ENTRY = entry_r;
   assign O_TORQUE_LIMIT = rd_sel.torque;
   assign O_PRESENT_ENTRY = present_r;
   assign O_SEQ_START = seq_start_r;
   assign O_COMPLETE = complete_r;

   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (!I_RST_N);

   a_ready_low_run: assert property (state_r == ST_RUN |-> !O_READY)
      else $error("ready high while a move runs");
   a_start_busy: assert property (O_MOVE_START |-> !O_READY && state_r == ST_RUN)
      else $error("move start pulse outside a running move");
   a_done_ready: assert property (state_r == ST_RUN && I_MOVE_DONE |=> O_READY && O_COMPLETE)
      else $error("completion not reported with ready");
   a_start_entry: assert property (O_READY && rise_start |=> O_MOVE_START && !O_READY
      && O_MOVE_ENTRY == $past(I_SEL))
      else $error("start did not run the selected entry");
   a_trig_entry: assert property (O_READY && !rise_start && rise_trig[0]
      |=> O_MOVE_START && O_MOVE_ENTRY == $past(map_r[0]))
      else $error("trigger 0 did not run its assigned entry");
   a_map_write: assert property (I_MAP_WE && int'(I_MAP_IDX) < NUM_TRIG
      |=> map_r[$past(I_MAP_IDX)] == $past(I_MAP_ENTRY))
      else $error("trigger assignment not stored");
   a_torque_sel: assert property (I_CFG_WE && I_CFG_ADDR == I_SEL ##1 !I_CFG_WE && $stable(I_SEL)
      |=> O_TORQUE_LIMIT == $past(I_CFG_DATA.torque, 2))
      else $error("torque limit not taken from the selected entry");
   a_step_next: assert property (O_READY && rise_step && !rise_start && rise_trig == '0
      && present_r != PRESENT_NONE |-> ##3 O_MOVE_START)
      else $error("step start did not begin a move in three cycles");
   a_step_wrap: assert property (state_r == ST_CHECK && !rd_run.seq_en
      |=> O_MOVE_ENTRY == $past(seq_start_r))
      else $error("disabled entry did not wrap to the sequence start");
   a_seq_record: assert property (O_READY && rise_start && !I_SEQ_RESET
      |=> O_SEQ_START == $past(I_SEL))
      else $error("start entry not recorded as sequence start");
   a_step_first: assert property (O_READY && rise_step && !rise_start && rise_trig == '0
      && present_r == PRESENT_NONE |=> O_MOVE_ENTRY == $past(seq_start_r))
      else $error("first step did not run the sequence start");
   a_seq_reset: assert property (I_SEQ_RESET
      |=> O_SEQ_START == SEQ_START_RST && O_PRESENT_ENTRY == PRESENT_NONE)
      else $error("sequence reset not applied");
   a_busy_ignore: assert property (state_r == ST_RUN && !I_MOVE_DONE |=> !O_MOVE_START)
      else $error("request taken while busy");
endmodule

// ### rtl/pss_pkg.sv
// Shared constants and types of the positioning start sequencer.
package pss_pkg;
   localparam int ENTRY_W = 4;
   localparam int N_ENTRY = 16;
   localparam int N_TRIG = 6;
   localparam int TORQUE_W = 8;
   localparam int TRIG_IDX_W = 3;
   localparam int PRESENT_W = ENTRY_W + 1;
   // Reset values.
   localparam logic [TORQUE_W-1:0] TORQUE_RST = 8'hFA;
   localparam logic SEQ_EN_RST = 1'b0;
   localparam logic [ENTRY_W-1:0] SEQ_START_RST = 4'h0;
   localparam logic [PRESENT_W-1:0] PRESENT_NONE = 5'h1F;
   // Least time the host keeps the select inputs steady before a start.
   localparam int SEL_HOLD_MS = 10;
   localparam int CLK_HZ = 20_000_000;
   localparam longint SEL_HOLD_CYC = (longint'(SEL_HOLD_MS) * CLK_HZ + 999) / 1000;

   typedef struct packed {
      logic seq_en;
      logic [TORQUE_W-1:0] torque;
   } entry_cfg_t;

   localparam entry_cfg_t ENTRY_CFG_RST = '{seq_en: SEQ_EN_RST, torque: TORQUE_RST};

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_CHECK = 2'b11,
      ST_RUN = 2'b10
   } seq_state_t;

   // Default entry assigned to a direct trigger is its own index.
   function automatic logic [ENTRY_W-1:0] map_default(input int k);
      map_default = ENTRY_W'(k);
   endfunction

   // Entry that follows e in a step sequence; 15 wraps to 0.
   function automatic logic [ENTRY_W-1:0] next_entry(input logic [ENTRY_W-1:0] e);
      next_entry = ENTRY_W'(e + 1'b1);
   endfunction
endpackage

// ### rtl/entry_table.sv
// Per-entry configuration store with two registered read ports.
`timescale 1ns/1ps
module entry_table import pss_pkg::*; #(
   parameter int DEPTH = N_ENTRY,
   parameter int AW = ENTRY_W
) (
   input wire logic i_clk, // System clock.
   input wire logic i_rst_n, // Asynchronous reset, active low.
   input wire logic i_we, // Write strobe.
   input wire logic [AW-1:0] i_waddr, // Write entry.
   input wire entry_cfg_t i_wdata, // Write data.
   input wire logic [AW-1:0] i_raddr_a, // Read entry, port A.
   output entry_cfg_t o_rdata_a, // Registered data, port A.
   input wire logic [AW-1:0] i_raddr_b, // Read entry, port B.
   output entry_cfg_t o_rdata_b // Registered data, port B.
);
   if (DEPTH != (1 << AW)) begin : g_bad_depth
      $error("entry_table: DEPTH must equal 2**AW");
   end

   entry_cfg_t mem_r [DEPTH];
   entry_cfg_t mem_nxt [DEPTH];
   entry_cfg_t rd_a_nxt;
   entry_cfg_t rd_b_nxt;

   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_nxt[i] = mem_r[i];
      end
      if (i_we) begin
         mem_nxt[i_waddr] = i_wdata;
      end
      rd_a_nxt = mem_r[i_raddr_a];
      rd_b_nxt = mem_r[i_raddr_b];
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= ENTRY_CFG_RST;
         end
         o_rdata_a <= ENTRY_CFG_RST;
         o_rdata_b <= ENTRY_CFG_RST;
      end else begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= mem_nxt[i];
         end
         o_rdata_a <= rd_a_nxt;
         o_rdata_b <= rd_b_nxt;
      end
   end
endmodule

// ### test/pss_host_model.sv
// Host controller and motion engine model that drives the sequencer's request inputs.
`timescale 1ns/1ps
module pss_host_model import pss_pkg::*; #(
   parameter int SEL_HOLD = 4
) (
   input wire logic i_clk, // System clock.
   input wire logic i_ready, // Ready from the sequencer.
   input wire logic i_move_start, // Move start pulse.
   input wire logic [ENTRY_W-1:0] i_move_entry, // Entry being executed.
   output logic [ENTRY_W-1:0] o_sel, // Binary entry select.
   output logic o_start, // Start request.
   output logic [N_TRIG-1:0] o_dtrig, // Direct triggers.
   output logic o_step, // Step start.
   output logic o_done // Motion finished.
);
   initial begin
      o_sel = 4'h0;
      o_start = 1'b0;
      o_dtrig = '0;
      o_step = 1'b0;
      o_done = 1'b0;
   end
   // Kind 0 is a start on entry idx, 1 is trigger idx, 2 is a step; ent is x if no move began.
   task automatic req(input int kind, input int idx, input int dly,
                      output logic [ENTRY_W-1:0] ent);
      int n;
      n = 0;
      while (i_ready !== 1'b1 && n < 100) begin
         @(negedge i_clk);
         n++;
      end
      if (kind == 0) begin
         o_sel = ENTRY_W'(idx);
         // The settle time is shortened so that a run stays brief.
         repeat (SEL_HOLD) @(negedge i_clk);
         o_start = 1'b1;
      end else if (kind == 1) begin
         o_dtrig[idx] = 1'b1;
      end else begin
         o_step = 1'b1;
      end
      n = 0;
      do begin
         @(posedge i_clk);
         #1;
         n++;
      end while (i_move_start !== 1'b1 && n < 10);
      ent = (i_move_start === 1'b1 && i_ready === 1'b0) ? i_move_entry : 'x;
      @(negedge i_clk);
      o_start = 1'b0;
      o_step = 1'b0;
      if (kind == 1) begin
         o_dtrig[idx] = 1'b0;
      end
      repeat (dly) @(negedge i_clk);
      o_done = 1'b1;
      @(negedge i_clk);
      o_done = 1'b0;
      n = 0;
      while (i_ready !== 1'b1 && n < 10) begin
         @(negedge i_clk);
         n++;
      end
   endtask
   // Raises a trigger while a move runs, against the host's own duty.
   task automatic rogue(input int k);
      @(negedge i_clk);
      o_dtrig[k] = 1'b1;
      repeat (2) @(negedge i_clk);
      o_dtrig[k] = 1'b0;
   endtask
endmodule

// ### test/test_positioning_start_sequencer.sv
// Self-checking testbench of the positioning start sequencer.
`timescale 1ns/1ps
module test_positioning_start_sequencer import pss_pkg::*;;
   logic I_CLK_SYS, I_RST_N, I_SEQ_RESET, I_MAP_WE, I_CFG_WE;
   logic [TRIG_IDX_W-1:0] I_MAP_IDX;
   logic [ENTRY_W-1:0] I_MAP_ENTRY, I_CFG_ADDR, sel, mv_ent, seq_st, ent;
   entry_cfg_t I_CFG_DATA;
   logic start, step, done, ready, mv_st, cmpl;
   logic [N_TRIG-1:0] dtrig;
   logic [TORQUE_W-1:0] torque;
   logic [PRESENT_W-1:0] present;
   int n_mismatch = 0, checks = 0, n_st = 0, n_cp = 0, s0;
   positioning_start_sequencer i_positioning_start_sequencer (.I_CLK_SYS(I_CLK_SYS),
      .I_RST_N(I_RST_N), .I_SEL(sel), .I_START(start), .I_DTRIG(dtrig),
      .I_STEP_START(step), .I_MOVE_DONE(done), .I_SEQ_RESET(I_SEQ_RESET), .I_MAP_WE(I_MAP_WE),
      .I_MAP_IDX(I_MAP_IDX), .I_MAP_ENTRY(I_MAP_ENTRY), .I_CFG_WE(I_CFG_WE),
      .I_CFG_ADDR(I_CFG_ADDR), .I_CFG_DATA(I_CFG_DATA), .O_READY(ready), .O_MOVE_START(mv_st),
      .O_MOVE_ENTRY(mv_ent), .O_TORQUE_LIMIT(torque), .O_PRESENT_ENTRY(present),
      .O_SEQ_START(seq_st), .O_COMPLETE(cmpl));
   pss_host_model i_pss_host_model (.i_clk(I_CLK_SYS), .i_ready(ready), .i_move_start(mv_st),
      .i_move_entry(mv_ent), .o_sel(sel), .o_start(start), .o_dtrig(dtrig), .o_step(step),
      .o_done(done));
   initial begin
      I_CLK_SYS = 1'b0;
      forever #25 I_CLK_SYS = ~I_CLK_SYS;
   end
   always @(posedge I_CLK_SYS) begin
      if (mv_st === 1'b1) n_st++;
      if (cmpl === 1'b1) n_cp++;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic run(input int kind, input int idx, input logic [3:0] exp);
      i_pss_host_model.req(kind, idx, 3, ent);
      chk(8'(ent), 8'(exp));
   endtask
   task automatic cfg(input logic [3:0] a, input logic en, input logic [7:0] tq);
      @(negedge I_CLK_SYS);
      I_CFG_WE = 1'b1;
      I_CFG_ADDR = a;
      I_CFG_DATA = '{seq_en: en, torque: tq};
      @(negedge I_CLK_SYS);
      I_CFG_WE = 1'b0;
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge I_CLK_SYS);
      n_mismatch++;
      end_of_test();
   end
   initial begin
      {I_RST_N, I_SEQ_RESET, I_MAP_WE, I_CFG_WE, I_MAP_IDX, I_MAP_ENTRY, I_CFG_ADDR} = '0;
      I_CFG_DATA = '0;
      repeat (6) @(negedge I_CLK_SYS);
      I_RST_N = 1'b1;
      chk(8'(ready), 8'h01);
      chk(8'(present), 8'h1F);
      chk(8'(seq_st), 8'h00);
      chk(torque, 8'hFA);
      cfg(4'h1, 1'b1, 8'hFA);
      cfg(4'h2, 1'b1, 8'hFA);
      cfg(4'h4, 1'b1, 8'hFA);
      cfg(4'h5, 1'b1, 8'hFA);
      run(2, 0, 4'h0);
      run(2, 0, 4'h1);
      run(2, 0, 4'h2);
      run(2, 0, 4'h0);
      run(0, 3, 4'h3);
      chk(8'(seq_st), 8'h03);
      run(2, 0, 4'h4);
      run(2, 0, 4'h5);
      run(2, 0, 4'h3);
      for (int e = 0; e < 16; e++) run(0, e, 4'(e));
      for (int k = 0; k < 6; k++) run(1, k, 4'(k));
      @(negedge I_CLK_SYS);
      {I_MAP_WE, I_MAP_IDX, I_MAP_ENTRY} = {1'b1, 3'h2, 4'hF};
      @(negedge I_CLK_SYS);
      I_MAP_WE = 1'b0;
      run(1, 2, 4'hF);
      chk(8'(seq_st), 8'h0F);
      run(2, 0, 4'hF);
      s0 = n_st;
      fork
         i_pss_host_model.req(0, 9, 20, ent);
         begin
            repeat (8) @(negedge I_CLK_SYS);
            chk(8'(ready), 8'h00);
            i_pss_host_model.rogue(1);
         end
      join
      chk(8'(ent), 8'h09);
      chk(8'(n_st - s0), 8'h01);
      chk(8'(present), 8'h09);
      i_pss_host_model.o_sel = 4'h7;
      cfg(4'h7, 1'b0, 8'h33);
      repeat (3) @(negedge I_CLK_SYS);
      chk(torque, 8'h33);
      run(1, 0, 4'h0);
      chk(torque, 8'h33);
      @(negedge I_CLK_SYS);
      I_SEQ_RESET = 1'b1;
      @(negedge I_CLK_SYS);
      I_SEQ_RESET = 1'b0;
      chk(8'(present), 8'h1F);
      chk(8'(seq_st), 8'h00);
      run(2, 0, 4'h0);
      // The last completion pulse is counted one edge after the model returns.
      @(negedge I_CLK_SYS);
      chk(8'(n_cp), 8'(n_st));
      end_of_test();
   end
endmodule
